/* design/lac_bridge.sv */
`timescale 1ns/10ps
module lac_bridge #(
    parameter int NUM_ALIAS = lac_pkg::LAC_NUM_ALIAS,
    parameter int THR_W     = lac_pkg::LAC_THR_W,
    parameter int SKEW_CYC  = lac_pkg::LAC_SKEW_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Mode and link state
    input  wire logic              camera_mode,
    input  wire logic              lock,
    // Configuration writes
    input  wire lac_pkg::lac_cfg_t cfg,
    input  wire logic              passthru_en,
    input  wire logic [THR_W-1:0]  err_thresh,
    input  wire logic              err_clear,
    // Received symbols
    input  wire lac_pkg::lac_sym_t sym,
    // Host address phase
    input  wire lac_pkg::lac_addr_t host_addr,
    input  wire logic              remote_done,
    // GPIO sync event
    input  wire logic              gpio_sync_in,
    // Outputs
    output lac_pkg::lac_addr_t     fwd_addr,
    output logic                   host_ack,
    output logic                   host_nack,
    output logic                   scl_stretch,
    output logic                   err_status_n,
    output logic [THR_W-1:0]       err_count,
    output logic                   gpio_sync_out
);
    import lac_pkg::*;

    // ------------------------------------------------------------
    // Alias table
    // ------------------------------------------------------------
    logic [6:0]         match_ff  [NUM_ALIAS];
    logic [6:0]         target_ff [NUM_ALIAS];
    logic [7:0]         cfg_off;
    logic               cfg_hit;
    logic [2:0]         cfg_slot;
    logic               match_we;
    logic               target_we;

    // Location decode shared by both halves of the table
    function automatic logic in_alias_map(input logic [7:0] a);
        return a >= LAC_ALIAS_BASE && a <= LAC_ALIAS_LAST;
    endfunction

    assign cfg_off   = cfg.addr - LAC_ALIAS_BASE;
    assign cfg_hit   = cfg.we && in_alias_map(cfg.addr);        // RULE_17
    assign cfg_slot  = cfg_off[3:1];
    // Even offset = match, odd = target; 7-bit address in [7:1]
    assign match_we  = ce && cfg_hit && !cfg_off[0];
    assign target_we = ce && cfg_hit && cfg_off[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_ALIAS; i++) begin
                match_ff[i] <= 7'h00;                         // RULE_19
            end
        end else if (match_we) begin
            match_ff[cfg_slot] <= cfg.data[7:1];              // RULE_07
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_ALIAS; i++) begin
                target_ff[i] <= 7'h00;                        // RULE_19
            end
        end else if (target_we) begin
            target_ff[cfg_slot] <= cfg.data[7:1];             // RULE_07
        end
    end

    // Zero match means an empty slot and never hits
    logic       hit;
    logic [6:0] hit_tgt;
    always_comb begin
        hit     = 1'b0;
        hit_tgt = host_addr.addr;
        for (int i = NUM_ALIAS - 1; i >= 0; i--) begin
            if (match_ff[i] != 7'h00
                && match_ff[i] == host_addr.addr) begin      // RULE_18
                hit     = 1'b1;
                hit_tgt = target_ff[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Proxy state machine
    // ------------------------------------------------------------
    lac_state_t state_ff;
    lac_state_t nxt_state;
    logic       alias_hit;
    logic       fwd_ok;
    logic       take;

    assign alias_hit = camera_mode && hit;                    // RULE_09
    // Pass-through gate applies regardless of mode
    assign fwd_ok    = passthru_en && (alias_hit || !camera_mode); // RULE_12
    // Address phases outside IDLE arrive mid-stretch and are dropped
    assign take      = (state_ff == LAC_IDLE) && host_addr.valid;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LAC_IDLE: begin
                if (host_addr.valid && fwd_ok)
                    nxt_state = LAC_HOLD;                     // RULE_10
            end
            LAC_HOLD: begin
                nxt_state = LAC_FWD;
            end
            LAC_FWD: begin
                if (remote_done)
                    nxt_state = LAC_IDLE;
            end
            default: begin
                nxt_state = LAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            state_ff <= LAC_IDLE;
        else if (ce)
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------
    // Host answer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            host_ack <= 1'b0;
        end else if (ce) begin
            host_ack <= take && fwd_ok;                       // RULE_16
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            host_nack <= 1'b0;
        end else if (ce) begin
            host_nack <= take && !fwd_ok;                     // RULE_11
        end
    end

    // ------------------------------------------------------------
    // Forwarded address
    // ------------------------------------------------------------
    // Address and direction hold between pulses; only valid is read
    always_ff @(posedge clk) begin
        if (rst) begin
            fwd_addr <= '0;
        end else if (ce) begin
            fwd_addr.valid <= take && fwd_ok;                 // RULE_10
            if (take && fwd_ok) begin
                fwd_addr.addr <= alias_hit ? hit_tgt
                                           : host_addr.addr;  // RULE_08
                fwd_addr.rnw  <= host_addr.rnw;               // RULE_18
            end
        end
    end

    // Clock held low until the remote side answers
    always_ff @(posedge clk) begin
        if (rst)
            scl_stretch <= 1'b0;
        else if (ce)
            scl_stretch <= (nxt_state != LAC_IDLE);           // RULE_16
    end

    // ------------------------------------------------------------
    // CRC check and error status
    // ------------------------------------------------------------
    logic       sym_ok;
    logic [3:0] crc_exp;
    logic       crc_bad;
    logic       thr_hit;

    // Compare the count this symbol will produce; one extra bit so
    // a saturated counter keeps meeting the threshold
    function automatic logic reach_thr(input logic [THR_W-1:0] cnt,
                                       input logic [THR_W-1:0] thr);
        logic [THR_W:0] next_cnt;
        next_cnt = {1'b0, cnt} + {{THR_W{1'b0}}, 1'b1};
        return next_cnt >= {1'b0, thr};
    endfunction

    // One CRC covers control byte, sync bits and pixels
    assign sym_ok  = sym.valid && lock;                       // RULE_02
    assign crc_exp = lac_crc(sym.ctrl, sym.hs, sym.vs, sym.pix); // RULE_05
    assign crc_bad = sym_ok && (sym.crc != crc_exp);          // RULE_01
    assign thr_hit = reach_thr(err_count, err_thresh);        // RULE_04

    // ------------------------------------------------------------
    // Error counter
    // ------------------------------------------------------------
    // A bad symbol wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            err_count <= '0;
        end else if (ce) begin
            if (crc_bad && err_count != '1) begin
                err_count <= err_count + 1'b1;               // RULE_01
            end else if (err_clear && !crc_bad) begin
                err_count <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Error status
    // ------------------------------------------------------------
    // Forced high while unlocked, since status means nothing then
    always_ff @(posedge clk) begin
        if (rst) begin
            err_status_n <= 1'b1;                             // RULE_19
        end else if (ce) begin
            if (!lock) begin
                err_status_n <= 1'b1;                         // RULE_02
            end else if (crc_bad && thr_hit) begin
                err_status_n <= 1'b0;                         // RULE_03
            end else if (err_clear) begin
                err_status_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // GPIO sync forwarding, bounded latency
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst)
            gpio_sync_out <= 1'b0;
        else if (ce)
            gpio_sync_out <= gpio_sync_in;                    // RULE_13
    end

endmodule // lac_bridge

/* design/lac_pkg.sv */
// Notes on behaviour
// RULE_01 - 4-bit CRC computed and checked per symbol
// RULE_02 - Error status valid only while locked
// RULE_03 - CRC mismatch drives error status low
// RULE_04 - Programmable threshold gates error interrupt
// RULE_05 - Check control, sync and pixel data
// RULE_06 - Host programs features via I2C slave
// RULE_07 - Eight alias match/target address pairs
// RULE_08 - Matched address replaced by target address
// RULE_09 - Aliasing only active in camera mode
// RULE_10 - Pass-through enabled forwards local traffic
// RULE_11 - Pass-through disabled blocks remote forwarding
// RULE_12 - Pass-through gating works in both modes
// RULE_13 - Inter-link GPIO skew at most 25 us
// RULE_14 - Host tracks remote peripherals and aliases
// RULE_15 - Host programs aliases before remote transfers
// RULE_16 - Ack and stretch on match, else nack
// RULE_17 - Alias settings at locations 0x08 to 0x17
// RULE_18 - Compare 7-bit address, keep R/W bit
// RULE_19 - Reset: aliases empty, defined enables
package lac_pkg;

    // ------------------------------------------------------------
    // Configuration map
    // ------------------------------------------------------------
    localparam logic [7:0] LAC_ALIAS_BASE   = 8'h08; // RULE_17
    localparam logic [7:0] LAC_ALIAS_LAST   = 8'h17; // RULE_17
    localparam int         LAC_NUM_ALIAS    = 8;
    localparam int         LAC_CRC_W        = 4;
    localparam int         LAC_PIX_W        = 16;
    localparam int         LAC_THR_W        = 8;
    localparam logic [7:0] LAC_THR_RST      = 8'h01;
    localparam logic       LAC_PASSTHRU_RST = 1'b1;
    localparam logic [4:0] LAC_CRC_POLY     = 5'h13;  // x^4+x+1
    localparam logic [3:0] LAC_CRC_INIT     = 4'hF;

    // ------------------------------------------------------------
    // GPIO skew limit
    // ------------------------------------------------------------
    localparam int LAC_CLK_MHZ      = 125;
    localparam int LAC_SKEW_US      = 25;
    localparam int LAC_SKEW_CYC     = LAC_SKEW_US * LAC_CLK_MHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 valid;
        logic [7:0]           ctrl;   // back-channel control byte
        logic                 hs;
        logic                 vs;
        logic [LAC_PIX_W-1:0] pix;
        logic [LAC_CRC_W-1:0] crc;
    } lac_sym_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic       rnw;
    } lac_addr_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } lac_cfg_t;

    typedef enum logic [2:0] {
        LAC_IDLE  = 3'b001,
        LAC_HOLD  = 3'b010,
        LAC_FWD   = 3'b100
    } lac_state_t;

    // Symbol CRC over all protected fields
    function automatic logic [3:0] lac_crc(
        input logic [7:0]  ctrl,
        input logic        hs,
        input logic        vs,
        input logic [15:0] pix
    );
        logic [25:0] d;
        logic [3:0]  c;
        logic        fb;
        d = {ctrl, hs, vs, pix};
        c = LAC_CRC_INIT;
        for (int i = 25; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], 1'b0} ^ (fb ? LAC_CRC_POLY[3:0] : 4'h0);
        end
        return c;
    endfunction

endpackage

/* verif/lac_bridge_props.sv */
`timescale 1ns/10ps
module lac_bridge_props
    import lac_pkg::*;
#(parameter int THR_W = 8) (
    input wire logic clk, rst, ce, camera_mode, lock, passthru_en,
    input wire logic err_clear, remote_done, gpio_sync_in,
    input wire lac_pkg::lac_cfg_t cfg,
    input wire logic [THR_W-1:0] err_thresh, err_count,
    input wire lac_pkg::lac_sym_t sym,
    input wire lac_pkg::lac_addr_t host_addr, fwd_addr,
    input wire logic host_ack, host_nack, scl_stretch, err_status_n,
    input wire logic gpio_sync_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        ce && host_addr.valid && !scl_stretch && !host_ack && !host_nack;
    endsequence
    AST_ONE_ANSWER: assert property (!(host_ack && host_nack))
        else $error("ack and nack together");
    AST_BLOCKED: assert property (s_take ##0 !passthru_en
        |=> host_nack && !fwd_addr.valid) else $error("blocked req passed");
    AST_ACK_FWD: assert property (host_ack
        |-> fwd_addr.valid && scl_stretch) else $error("ack without fwd");
    AST_HOLD: assert property (scl_stretch && !remote_done
        |=> scl_stretch) else $error("stretch dropped early");
    AST_DROP: assert property (ce && scl_stretch && remote_done
        |-> ##[1:2] !scl_stretch) else $error("stretch stuck");
    AST_RNW: assert property (fwd_addr.valid
        |-> fwd_addr.rnw == $past(host_addr.rnw)) else $error("rnw lost");
    AST_DISPLAY: assert property (fwd_addr.valid && !$past(camera_mode)
        |-> fwd_addr.addr == $past(host_addr.addr)) else $error("remapped");
    AST_UNLOCKED: assert property (ce && !lock |=> err_status_n)
        else $error("status low while unlocked");
    AST_THRESH: assert property ($fell(err_status_n)
        |-> $past(lock) && err_count >= err_thresh)
        else $error("early status");
    AST_CNT: assert property (err_count != $past(err_count)
        |-> err_count == $past(err_count) + 1 || err_count == 0)
        else $error("count jump");
    AST_GPIO: assert property (ce
        |=> gpio_sync_out == $past(gpio_sync_in)) else $error("gpio lag");
endmodule // lac_bridge_props

/* verif/lac_remote_model.sv */
`timescale 1ns/10ps
module lac_remote_model
    import lac_pkg::*;
(
    input wire logic clk, rst, slow,
    input wire lac_pkg::lac_addr_t fwd,
    output logic remote_done
);
    logic [4:0] cnt_ff;
    // Remote slave answers after a short or a long wait
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 5'h00;
            remote_done <= 1'b0;
        end else begin
            remote_done <= (cnt_ff == 5'h01);
            if (fwd.valid)
                cnt_ff <= slow ? 5'h14 : 5'h03;
            else if (cnt_ff != 5'h00)
                cnt_ff <= cnt_ff - 5'h01;
        end
    end
endmodule // lac_remote_model

/* verif/lac_bridge_tb.sv */
`timescale 1ns/10ps
module lac_bridge_tb;
    import lac_pkg::*;
    logic clk, rst, ce, camera_mode, lock, passthru_en, err_clear, slow;
    logic remote_done, gpio_sync_in, host_ack, host_nack, scl_stretch;
    logic err_status_n, gpio_sync_out;
    logic [7:0] err_thresh, err_count;
    lac_cfg_t cfg;
    lac_sym_t sym;
    lac_addr_t host_addr, fwd_addr;
    logic [25:0] flips [3] = '{26'h0040000, 26'h0020000, 26'h0000001};
    int num_errors = 0;
    int n_compared = 0;
    lac_bridge uut (.*);
    lac_remote_model peer (.clk(clk), .rst(rst), .slow(slow),
        .fwd(fwd_addr), .remote_done(remote_done));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [3:0] crc4(logic [25:0] d);
        logic [3:0] c;
        c = 4'hF;
        for (int i = 25; i >= 0; i--)
            c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
        return c;
    endfunction
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [6:0] v);
        cfg = '{1'b1, a, {v, 1'b0}};
        tick;
    endtask
    task automatic req(logic [6:0] a, logic rw, logic ok, logic [6:0] ta);
        host_addr = '{1'b1, a, rw};
        tick;
        host_addr.valid = 1'b0;
        chk("ack", 8'(ok), {7'h00, host_ack});
        chk("nack", 8'(!ok), {7'h00, host_nack});
        chk("fwd", ok ? {ta, rw} : 8'h00,
            fwd_addr.valid ? {fwd_addr.addr, fwd_addr.rnw} : 8'h00);
        for (int i = 0; i < 40 && scl_stretch !== 1'b0; i++)
            tick;
        chk("stretch", 8'h00, {7'h00, scl_stretch});
        tick;
    endtask
    task automatic symb(logic [25:0] d, logic [25:0] x);
        logic [25:0] v;
        v = d ^ x;
        sym = '{1'b1, v[25:18], v[17], v[16], v[15:0], crc4(d)};
        tick;
        sym.valid = 1'b0;
        tick;
    endtask
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        {rst, ce, camera_mode, passthru_en} = 4'hF;
        {lock, err_clear, gpio_sync_in, slow} = 4'h0;
        err_thresh = 8'h03;
        cfg = '0;
        sym = '0;
        host_addr = '0;
        repeat (4) tick;
        rst = 1'b0;
        chk("status", 8'h01, {7'h00, err_status_n});
        chk("count", 8'h00, err_count);
        req(7'h51, 1'b0, 1'b0, 7'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            wr(LAC_ALIAS_BASE + 8'(2 * i), 7'h51 + 7'(i));
            wr(LAC_ALIAS_BASE + 8'(2 * i + 1), 7'h50 + 7'(i));
        end
        cfg.we = 1'b0;
        for (int i = 0; i < 8; i++) begin
            slow = i[0];
            req(7'h51 + 7'(i), i[1], 1'b1, 7'h50 + 7'(i));
        end
        req(7'h3F, 1'b1, 1'b0, 7'h00);
        $display("alias test done");
        camera_mode = 1'b0;
        req(7'h51, 1'b1, 1'b1, 7'h51);
        passthru_en = 1'b0;
        req(7'h51, 1'b0, 1'b0, 7'h00);
        camera_mode = 1'b1;
        req(7'h51, 1'b0, 1'b0, 7'h00);
        passthru_en = 1'b1;
        req(7'h51, 1'b0, 1'b1, 7'h50);
        $display("pass-through test done");
        lock = 1'b1;
        symb(26'h0ABCDEF, 26'h0);
        chk("count", 8'h00, err_count);
        for (int k = 0; k < 3; k++) begin
            symb(26'h0ABCDEF, flips[k]);
            chk("count", 8'(k + 1), err_count);
            chk("status", 8'(k < 2), {7'h00, err_status_n});
        end
        err_clear = 1'b1;
        tick;
        err_clear = 1'b0;
        tick;
        chk("count", 8'h00, err_count);
        chk("status", 8'h01, {7'h00, err_status_n});
        lock = 1'b0;
        symb(26'h0ABCDEF, 26'h0000001);
        chk("count", 8'h00, err_count);
        chk("status", 8'h01, {7'h00, err_status_n});
        $display("crc test done");
        ce = 1'b0;
        gpio_sync_in = 1'b1;
        tick;
        chk("gpio", 8'h00, {7'h00, gpio_sync_out});
        ce = 1'b1;
        tick;
        chk("gpio", 8'h01, {7'h00, gpio_sync_out});
        $display("gpio test done");
        end_of_test;
    end
endmodule // lac_bridge_tb
bind lac_bridge lac_bridge_props #(.THR_W(THR_W)) props_i (.*);
